// ===== pkg/cefc_map.svh
// Register offsets, reset values, field positions and codes of the
// camera exposure and format control bank.
// Assumes byte-wide registers reached through an 8-bit address port.
`ifndef CEFC_MAP_SVH
`define CEFC_MAP_SVH

// Offsets
`define CEFC_ADDR_EXP_HI      8'h08
`define CEFC_ADDR_PLL         8'h0D
`define CEFC_ADDR_EXP_LO      8'h10
`define CEFC_ADDR_CLK         8'h11
`define CEFC_ADDR_FMT         8'h12
`define CEFC_ADDR_AEN         8'h13
`define CEFC_ADDR_GCEIL       8'h14

// Reset values
`define CEFC_RST_EXP_HI       8'h00
`define CEFC_RST_PLL          8'h41
`define CEFC_RST_EXP_LO       8'h40
`define CEFC_RST_CLK          8'h80
`define CEFC_RST_FMT          8'h00
`define CEFC_RST_AEN          8'h8F
`define CEFC_RST_GCEIL        8'h4A
`define CEFC_UNMAPPED_DATA    8'h00

// Clock control fields
`define CEFC_CLK_BYPASS_BIT   6
`define CEFC_CLK_PRE_MSB      5
`define CEFC_PLL_MSB          7
`define CEFC_PLL_LSB          6

// Format and reset control fields
`define CEFC_FMT_SOFT_RST_BIT 7
`define CEFC_FMT_RES_BIT      6
`define CEFC_FMT_BT656_BIT    5
`define CEFC_FMT_RAW_BIT      4
`define CEFC_FMT_RGB_MSB      3
`define CEFC_FMT_RGB_LSB      2
`define CEFC_FMT_OUT_MSB      1

// Automatic control enable fields
`define CEFC_AEN_FAST_BIT     7
`define CEFC_AEN_STEP_BIT     6
`define CEFC_AEN_BAND_BIT     5
`define CEFC_AEN_SUBBAND_BIT  4
`define CEFC_AEN_FINE_BIT     3
`define CEFC_AEN_GAIN_BIT     2
`define CEFC_AEN_WB_BIT       1
`define CEFC_AEN_EXP_BIT      0

// Gain ceiling fields
`define CEFC_GC_HIST_BIT      7
`define CEFC_GC_CAP_MSB       6
`define CEFC_GC_CAP_LSB       4
`define CEFC_GC_DROP_FS_BIT   2
`define CEFC_GC_DROP_LV_BIT   1
`define CEFC_GC_CAP_MAX       3'h4

// Gain ceiling and clock plan figures
`define CEFC_GAIN_BASE        6'h02
`define CEFC_GAIN_TOP         6'h20
`define CEFC_MULT_NONE        4'h1
`define CEFC_MULT_4X          4'h4
`define CEFC_MULT_6X          4'h6
`define CEFC_MULT_8X          4'h8
`define CEFC_DIV_NONE         8'h01

`endif

// ===== pkg/cefc_pkg.sv
// Types of the camera exposure and format control bank.
// Assumes the map header for the numeric codes.
package cefc_pkg;

  typedef enum logic {
    CEFC_RES_VGA  = 1'b0,
    CEFC_RES_QVGA = 1'b1
  } cefc_res_type;

  typedef enum logic [1:0] {
    CEFC_OUT_YUV      = 2'h0,
    CEFC_OUT_PROC_RAW = 2'h1,
    CEFC_OUT_RGB      = 2'h2,
    CEFC_OUT_RAW      = 2'h3
  } cefc_out_fmt_type;

  typedef enum logic [1:0] {
    CEFC_RGB_GBR422  = 2'h0,
    CEFC_RGB_565     = 2'h1,
    CEFC_RGB_565_ALT = 2'h2,
    CEFC_RGB_444     = 2'h3
  } cefc_rgb_fmt_type;

endpackage

// ===== pkg/cefc_sync_if.sv
// Sync signals between the register bank and the sync drop gate.
// Assumes both ends run on mclk.
`timescale 1ns/1ps
`default_nettype none

interface cefc_sync_if;
  logic drop_fs;
  logic drop_lv;
  logic corrupt;
  logic fs_in;
  logic lv_in;
  logic fs_out;
  logic lv_out;

  modport ctrl (output drop_fs, drop_lv, corrupt, fs_in, lv_in,
                input  fs_out, lv_out);
  modport gate (input  drop_fs, drop_lv, corrupt, fs_in, lv_in,
                output fs_out, lv_out);
endinterface

`default_nettype wire

// ===== verilog/cefc_sync_gate.sv
// Sync drop gate: removes frame sync and line valid of corrupt frames.
// Assumes sync inputs come from pipeline logic on mclk.
`timescale 1ns/1ps
`default_nettype none
`include "cefc_map.svh"

module cefc_sync_gate
  import cefc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Sync path
  cefc_sync_if.gate sy
);

  ////////////////////////////////////////////////////////////////////////
  // Frame sync and line valid drop
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sy.fs_out <= 1'b0;
    end else begin
      sy.fs_out <= sy.fs_in && !(sy.drop_fs && sy.corrupt);
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sy.lv_out <= 1'b0;
    end else begin
      sy.lv_out <= sy.lv_in && !(sy.drop_lv && sy.corrupt);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  property p_drop_fs;
    @(posedge mclk) disable iff (!nrst)
      (sy.drop_fs && sy.corrupt) |=> !sy.fs_out;
  endproperty
  a_drop_fs: assert property (p_drop_fs)
    else $error("frame sync passed on a corrupt frame");

  property p_drop_lv;
    @(posedge mclk) disable iff (!nrst)
      (sy.lv_in && !(sy.drop_lv && sy.corrupt)) |=> sy.lv_out;
  endproperty
  a_drop_lv: assert property (p_drop_lv)
    else $error("line valid lost on a good frame");

endmodule // cefc_sync_gate

`default_nettype wire

// ===== verilog/cefc_regs.sv
// Camera exposure and format control register bank.
// Assumes the serial control slave outside turns bus cycles into
// single-cycle read and write strobes on mclk, and that the pipeline
// sync and auto exposure inputs are on mclk as well.
`timescale 1ns/1ps
`default_nettype none
`include "cefc_map.svh"

module cefc_regs
  import cefc_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              nrst,
  // Register access port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  output logic                   reg_rvalid,
  // Auto exposure engine
  input  wire logic              exp_upd,
  input  wire logic [15:0]       exp_upd_value,
  // Video sync
  input  wire logic              frame_corrupt,
  input  wire logic              frame_sync_in,
  input  wire logic              line_valid_in,
  output logic                   frame_sync_out,
  output logic                   line_valid_out,
  // Exposure and gain control
  output logic      [15:0]       exposure_value,
  output logic                   fast_auto,
  output logic                   step_unlimited,
  output logic                   band_filter_on,
  output logic                   below_band_ok,
  output logic                   fine_exposure_ok,
  output logic                   gain_auto,
  output logic                   wb_auto,
  output logic                   exp_auto,
  output logic                   histogram_mode,
  output logic      [5:0]        gain_ceiling_x,
  // Clock plan
  output logic                   clk_bypass,
  output logic      [3:0]        clk_mult,
  output logic      [7:0]        clk_div,
  // Output format
  output cefc_res_type           resolution,
  output logic                   bt656_on,
  output logic                   sensor_raw,
  output cefc_out_fmt_type       out_format,
  output cefc_rgb_fmt_type       rgb_format
);

  logic [7:0] exp_hi_reg;
  logic [7:0] exp_lo_reg;
  logic [7:0] pll_reg;
  logic [7:0] clk_reg;
  logic [7:0] fmt_reg;
  logic [7:0] aen_reg;
  logic [7:0] gc_reg;
  logic       soft_rst;
  logic       auto_load;
  logic [7:0] rdata_next;

  cefc_sync_if sy ();

  ////////////////////////////////////////////////////////////////////////
  // Write decode
  // Soft reset strobe
  assign soft_rst = reg_wr && (reg_addr == `CEFC_ADDR_FMT)
                    && reg_wdata[`CEFC_FMT_SOFT_RST_BIT];
  assign auto_load = exp_upd && aen_reg[`CEFC_AEN_EXP_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Exposure registers; the engine wins over a host write in one cycle
  always_ff @(posedge mclk) begin
    if (!nrst || soft_rst) begin
      exp_hi_reg <= `CEFC_RST_EXP_HI;
    end else if (auto_load) begin
      exp_hi_reg <= exp_upd_value[15:8];
    end else if (reg_wr && reg_addr == `CEFC_ADDR_EXP_HI) begin
      exp_hi_reg <= reg_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst || soft_rst) begin
      exp_lo_reg <= `CEFC_RST_EXP_LO;
    end else if (auto_load) begin
      exp_lo_reg <= exp_upd_value[7:0];
    end else if (reg_wr && reg_addr == `CEFC_ADDR_EXP_LO) begin
      exp_lo_reg <= reg_wdata;
    end
  end

  // Control registers
  always_ff @(posedge mclk) begin
    if (!nrst || soft_rst) begin
      pll_reg <= `CEFC_RST_PLL;
    end else if (reg_wr && reg_addr == `CEFC_ADDR_PLL) begin
      pll_reg <= reg_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst || soft_rst) begin
      clk_reg <= `CEFC_RST_CLK;
    end else if (reg_wr && reg_addr == `CEFC_ADDR_CLK) begin
      clk_reg <= reg_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst || soft_rst) begin
      fmt_reg <= `CEFC_RST_FMT;
    end else if (reg_wr && reg_addr == `CEFC_ADDR_FMT) begin
      fmt_reg <= {1'b0, reg_wdata[6:0]};
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst || soft_rst) begin
      aen_reg <= `CEFC_RST_AEN;
    end else if (reg_wr && reg_addr == `CEFC_ADDR_AEN) begin
      aen_reg <= reg_wdata;
    end
  end

  // Illegal ceiling codes are stored; the decode clamps them
  always_ff @(posedge mclk) begin
    if (!nrst || soft_rst) begin
      gc_reg <= `CEFC_RST_GCEIL;
    end else if (reg_wr && reg_addr == `CEFC_ADDR_GCEIL) begin
      gc_reg <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path: data one cycle after the strobe, old value on a collision
  always_comb begin
    unique case (reg_addr)
      `CEFC_ADDR_EXP_HI: rdata_next = exp_hi_reg;
      `CEFC_ADDR_PLL:    rdata_next = pll_reg;
      `CEFC_ADDR_EXP_LO: rdata_next = exp_lo_reg;
      `CEFC_ADDR_CLK:    rdata_next = clk_reg;
      `CEFC_ADDR_FMT:    rdata_next = fmt_reg;
      `CEFC_ADDR_AEN:    rdata_next = aen_reg;
      `CEFC_ADDR_GCEIL:  rdata_next = gc_reg;
      default:           rdata_next = `CEFC_UNMAPPED_DATA;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Exposure word
  assign exposure_value = {exp_hi_reg, exp_lo_reg};

  assign fast_auto      = aen_reg[`CEFC_AEN_FAST_BIT];
  assign step_unlimited = aen_reg[`CEFC_AEN_STEP_BIT];
  assign band_filter_on = aen_reg[`CEFC_AEN_BAND_BIT];
  // Sub-band only counts with the filter on
  assign below_band_ok  = !aen_reg[`CEFC_AEN_BAND_BIT]
                          || aen_reg[`CEFC_AEN_SUBBAND_BIT];
  assign fine_exposure_ok = aen_reg[`CEFC_AEN_FINE_BIT];
  assign gain_auto = aen_reg[`CEFC_AEN_GAIN_BIT];
  assign wb_auto   = aen_reg[`CEFC_AEN_WB_BIT];
  assign exp_auto  = aen_reg[`CEFC_AEN_EXP_BIT];
  assign histogram_mode = gc_reg[`CEFC_GC_HIST_BIT];

  // Gain cap, clamped to the top on illegal codes
  always_comb begin
    if (gc_reg[`CEFC_GC_CAP_MSB:`CEFC_GC_CAP_LSB] > `CEFC_GC_CAP_MAX) begin
      gain_ceiling_x = `CEFC_GAIN_TOP;
    end else begin
      gain_ceiling_x = `CEFC_GAIN_BASE
                       << gc_reg[`CEFC_GC_CAP_MSB:`CEFC_GC_CAP_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // PLL multiplier
  always_comb begin
    unique case (pll_reg[`CEFC_PLL_MSB:`CEFC_PLL_LSB])
      2'h0: clk_mult = `CEFC_MULT_NONE;
      2'h1: clk_mult = `CEFC_MULT_4X;
      2'h2: clk_mult = `CEFC_MULT_6X;
      2'h3: clk_mult = `CEFC_MULT_8X;
    endcase
  end

  // Divider; bypass takes the input as is
  assign clk_bypass = clk_reg[`CEFC_CLK_BYPASS_BIT];
  assign clk_div    = clk_bypass ? `CEFC_DIV_NONE
                      : 8'(({2'h0, clk_reg[`CEFC_CLK_PRE_MSB:0]} + 8'h01)
                           << 1);

  assign resolution = cefc_res_type'(fmt_reg[`CEFC_FMT_RES_BIT]);
  assign bt656_on   = fmt_reg[`CEFC_FMT_BT656_BIT];
  assign sensor_raw = fmt_reg[`CEFC_FMT_RAW_BIT];
  assign out_format = cefc_out_fmt_type'(fmt_reg[`CEFC_FMT_OUT_MSB:0]);
  assign rgb_format = cefc_rgb_fmt_type'(
                        fmt_reg[`CEFC_FMT_RGB_MSB:`CEFC_FMT_RGB_LSB]);

  ////////////////////////////////////////////////////////////////////////
  // Drop controls to the gate
  assign sy.drop_fs = gc_reg[`CEFC_GC_DROP_FS_BIT];
  assign sy.drop_lv = gc_reg[`CEFC_GC_DROP_LV_BIT];
  assign sy.corrupt = frame_corrupt;
  assign sy.fs_in   = frame_sync_in;
  assign sy.lv_in   = line_valid_in;
  assign frame_sync_out = sy.fs_out;
  assign line_valid_out = sy.lv_out;

  cefc_sync_gate u_gate (
    .mclk (mclk),
    .nrst (nrst),
    .sy   (sy.gate)
  );

  ////////////////////////////////////////////////////////////////////////
  property p_exp_lo_write;
    @(posedge mclk) disable iff (!nrst)
      (reg_wr && reg_addr == `CEFC_ADDR_EXP_LO && !auto_load)
      |=> exposure_value[7:0] == $past(reg_wdata);
  endproperty
  a_exp_lo_write: assert property (p_exp_lo_write)
    else $error("exposure low byte did not take the write");

  property p_bypass;
    @(posedge mclk) disable iff (!nrst)
      (reg_wr && reg_addr == `CEFC_ADDR_CLK && reg_wdata[6] && !soft_rst)
      |=> clk_bypass && clk_div == 8'h01;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("clock bypass not applied");

  property p_div;
    @(posedge mclk) disable iff (!nrst)
      (reg_wr && reg_addr == `CEFC_ADDR_CLK && !reg_wdata[6])
      |=> clk_div == 8'(({2'h0, $past(reg_wdata[5:0])} + 8'h01) << 1);
  endproperty
  a_div: assert property (p_div)
    else $error("clock divisor wrong");

  property p_soft_rst;
    @(posedge mclk) disable iff (!nrst)
      soft_rst |=> aen_reg == `CEFC_RST_AEN && gc_reg == `CEFC_RST_GCEIL
                   && clk_reg == `CEFC_RST_CLK && fmt_reg == `CEFC_RST_FMT;
  endproperty
  a_soft_rst: assert property (p_soft_rst)
    else $error("soft reset left a register changed");

  property p_res;
    @(posedge mclk) disable iff (!nrst)
      (reg_wr && reg_addr == `CEFC_ADDR_FMT && !reg_wdata[7])
      |=> resolution == cefc_res_type'($past(reg_wdata[6]))
          && out_format == cefc_out_fmt_type'($past(reg_wdata[1:0]));
  endproperty
  a_res: assert property (p_res)
    else $error("format fields did not follow the write");

  property p_gain_cap;
    @(posedge mclk) disable iff (!nrst)
      gain_ceiling_x inside {6'h02, 6'h04, 6'h08, 6'h10, 6'h20};
  endproperty
  a_gain_cap: assert property (p_gain_cap)
    else $error("gain ceiling outside 2x to 32x");

  property p_auto_exp;
    @(posedge mclk) disable iff (!nrst)
      (auto_load && !soft_rst) |=> exposure_value == $past(exp_upd_value);
  endproperty
  a_auto_exp: assert property (p_auto_exp)
    else $error("auto exposure value not loaded");

  property p_rst_bit_rd;
    @(posedge mclk) disable iff (!nrst)
      (reg_rd && reg_addr == `CEFC_ADDR_FMT) |=> reg_rvalid && !reg_rdata[7];
  endproperty
  a_rst_bit_rd: assert property (p_rst_bit_rd)
    else $error("soft reset bit read back as one");

endmodule // cefc_regs

`default_nettype wire

// ===== tb/cefc_host_model.sv
// Host side of the control bus, seen as the strobe port of the bank.
// Assumes the bench calls wr and rd one at a time, and that both
// start and finish on falling edges of mclk.
`timescale 1ns/1ps
`default_nettype none

module cefc_host_model (
  // Clock
  input  wire logic       mclk,
  // Strobe port toward the bank
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // Released lines show the inverse, so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == 8'h14 && v[6:4] > 3'h4) v[6:4] = 3'h4;
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~v;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output bit ok);
    int n;
    ok = 1'b0;
    d = 8'h00;
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    for (n = 0; n < 4 && !ok; n++) begin
      if (reg_rvalid === 1'b1) begin
        d = reg_rdata;
        ok = 1'b1;
      end else begin
        @(negedge mclk);
      end
    end
  endtask
endmodule // cefc_host_model

`default_nettype wire

// ===== tb/cefc_regs_tb.sv
// Self-checking bench of the exposure and format control bank.
// Assumes the host model for bus cycles; a reference model of
// integers predicts every read and every decoded output.
`timescale 1ns/1ps
`default_nettype none

module cefc_regs_tb;
  import cefc_pkg::*;
  logic        mclk, nrst;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, clk_div;
  logic        reg_wr, reg_rd, reg_rvalid, exp_upd;
  logic [15:0] exp_upd_value, exposure_value;
  logic        frame_corrupt, frame_sync_in, line_valid_in;
  logic        frame_sync_out, line_valid_out, fast_auto, step_unlimited;
  logic        band_filter_on, below_band_ok, fine_exposure_ok, gain_auto;
  logic        wb_auto, exp_auto, histogram_mode, clk_bypass;
  logic        bt656_on, sensor_raw, pfs, plv, pc;
  logic [5:0]  gain_ceiling_x;
  logic [3:0]  clk_mult;
  logic [7:0]  rb;
  cefc_res_type     resolution;
  cefc_out_fmt_type out_format;
  cefc_rgb_fmt_type rgb_format;
  int     miscompares = 0;
  int     tests_run = 0;
  integer seed = 32'h0000_c1e7;
  int     m [0:255];
  int     mt [0:3] = '{1, 4, 6, 8};
  int     addrs [0:7] = '{8'h08, 8'h0D, 8'h10, 8'h11, 8'h12, 8'h13,
                          8'h14, 8'h04};
  int     i, a, d, v;
  bit     ok;

  cefc_regs uut (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .reg_rvalid, .exp_upd, .exp_upd_value, .frame_corrupt,
    .frame_sync_in, .line_valid_in, .frame_sync_out, .line_valid_out,
    .exposure_value, .fast_auto, .step_unlimited, .band_filter_on,
    .below_band_ok, .fine_exposure_ok, .gain_auto, .wb_auto, .exp_auto,
    .histogram_mode, .gain_ceiling_x, .clk_bypass, .clk_mult, .clk_div,
    .resolution, .bt656_on, .sensor_raw, .out_format, .rgb_format);

  cefc_host_model host (.mclk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .reg_rvalid);

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
      miscompares++;
    end
  endtask

  task automatic mdl_reset();
    m = '{default: 0};
    m[8'h0D] = 8'h41;
    m[8'h10] = 8'h40;
    m[8'h11] = 8'h80;
    m[8'h13] = 8'h8F;
    m[8'h14] = 8'h4A;
  endtask

  task automatic mdl_wr(input int a, input int d);
    if (!(a inside {8'h08, 8'h0D, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14}))
      return;
    if (a == 8'h12 && (d >> 7 & 1) == 1) mdl_reset();
    else m[a] = d;
  endtask

  task automatic chk_rd(input int a);
    host.rd(8'(a), rb, ok);
    if (!ok) begin
      $display("wrong value at %0t: no read answer", $time);
      miscompares++;
      end_sim();
    end else begin
      chk(16'(rb), 16'(m[a]));
    end
  endtask

  task automatic chk_out();
    int c, e, f;
    c = m[8'h14] >> 4 & 7;
    e = m[8'h13];
    f = m[8'h11];
    chk(exposure_value, 16'(m[8'h08] * 256 + m[8'h10]));
    chk(16'(clk_bypass), 16'(f >> 6 & 1));
    chk(16'(clk_div), 16'((f >> 6 & 1) ? 1 : 2 * ((f & 63) + 1)));
    chk(16'(clk_mult), 16'(mt[m[8'h0D] >> 6 & 3]));
    chk(16'(resolution), 16'(m[8'h12] >> 6 & 1));
    chk(16'(bt656_on), 16'(m[8'h12] >> 5 & 1));
    chk(16'(sensor_raw), 16'(m[8'h12] >> 4 & 1));
    chk(16'(out_format), 16'(m[8'h12] & 3));
    chk(16'(rgb_format), 16'(m[8'h12] >> 2 & 3));
    chk(16'(fast_auto), 16'(e >> 7 & 1));
    chk(16'(step_unlimited), 16'(e >> 6 & 1));
    chk(16'(band_filter_on), 16'(e >> 5 & 1));
    chk(16'(fine_exposure_ok), 16'(e >> 3 & 1));
    chk(16'({gain_auto, wb_auto, exp_auto}), 16'(e & 7));
    chk(16'(below_band_ok), 16'(!(e >> 5 & 1) || (e >> 4 & 1)));
    chk(16'(histogram_mode), 16'(m[8'h14] >> 7 & 1));
    chk(16'(gain_ceiling_x), 16'(c > 4 ? 32 : 2 << c));
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    #1_000_000;
    $display("wrong value at %0t: run did not finish", $time);
    miscompares++;
    end_sim();
  end

  initial begin
    nrst = 1'b0;
    exp_upd = 1'b0;
    exp_upd_value = 16'h0000;
    frame_corrupt = 1'b0;
    frame_sync_in = 1'b0;
    line_valid_in = 1'b0;
    {pfs, plv, pc} = 3'h0;
    mdl_reset();
    repeat (6) @(negedge mclk);
    nrst = 1'b1;
    // Defaults, then random writes each read back; bit 7 of 0x12 resets
    for (i = 0; i < 8; i++) chk_rd(addrs[i]);
    chk_out();
    for (i = 0; i < 200; i++) begin
      a = addrs[$unsigned($random(seed)) % 8];
      d = $random(seed) & 255;
      if (a == 8'h14 && (d >> 4 & 7) > 4) d = d & 8'h8F | 8'h40;
      host.wr(8'(a), 8'(d));
      mdl_wr(a, d);
      chk_rd(a);
      chk_out();
    end
    host.wr(8'h12, 8'h80);
    mdl_wr(8'h12, 8'h80);
    for (i = 0; i < 8; i++) chk_rd(addrs[i]);
    // Hardware reset in mid-run restores the same defaults
    host.wr(8'h13, 8'h00);
    mdl_wr(8'h13, 8'h00);
    @(negedge mclk);
    nrst = 1'b0;
    repeat (2) @(negedge mclk);
    nrst = 1'b1;
    mdl_reset();
    for (i = 0; i < 8; i++) chk_rd(addrs[i]);
    chk_out();
    // Engine update on the same edge as a host write to the low byte
    for (i = 0; i < 6; i++) begin
      host.wr(8'h13, 8'(8'h8E | i & 1));
      mdl_wr(8'h13, 8'h8E | i & 1);
      v = $random(seed) & 16'hFFFF;
      d = $random(seed) & 255;
      fork
        host.wr(8'h10, 8'(d));
        begin
          @(negedge mclk);
          exp_upd = 1'b1;
          exp_upd_value = 16'(v);
          @(negedge mclk);
          exp_upd = 1'b0;
        end
      join
      mdl_wr(8'h10, d);
      if ((i & 1) == 1) begin
        m[8'h08] = v >> 8;
        m[8'h10] = v & 255;
      end
      chk_out();
      chk_rd(8'h08);
      chk_rd(8'h10);
    end
    // Sync outputs lag one edge and drop while a corrupt frame is flagged and their drop bit in 0x14 is set
    for (i = 0; i < 120; i++) begin
      if (i % 20 == 0) begin
        d = $random(seed) & 8'h06 | 8'h40;
        host.wr(8'h14, 8'(d));
        mdl_wr(8'h14, d);
      end
      @(negedge mclk);
      chk(16'(frame_sync_out), 16'(pfs && !(m[20][2] && pc)));
      chk(16'(line_valid_out), 16'(plv && !(m[20][1] && pc)));
      pfs = 1'($random(seed));
      plv = 1'($random(seed));
      pc = 1'($random(seed));
      frame_sync_in = pfs;
      line_valid_in = plv;
      frame_corrupt = pc;
    end
    end_sim();
  end
endmodule // cefc_regs_tb

`default_nettype wire
